// [core/psw_power_ctrl.sv]
`timescale 1ns/1ns
module psw_power_ctrl
	import psw_pkg::*;
#(
	parameter int PULSE_CYCLES = PSW_WAKE_PULSE_CYCLES,
	parameter int READY_CYCLES = PSW_READY_CYCLES
)
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic wake_frame_hit,
	input wire logic carrier_detect,
	output psw_gate_t clk_gates,
	output logic wake_frame_detect_armed,
	output logic ready,
	output logic host_irq,
	output logic wake_event_out
);

	localparam int RW = $clog2(READY_CYCLES + 1);

	logic carrier_meta;
	logic carrier_sync;
	psw_state_t state;
	psw_state_t next_state;
	psw_ctrl_t ctrl;
	logic pme_int;
	logic pme_int_en;
	logic [31:0] scratch;
	logic read_seen;
	logic [RW-1:0] ready_cnt;
	logic dp_valid;
	logic dp_write;
	logic [7:0] dp_addr;
	logic ap_valid;
	logic write_ok;
	logic wake_write;
	logic ctrl_write;
	logic sts_write;
	logic en_write;
	logic det_frame;
	logic det_energy;
	logic pme_line;
	logic [31:0] next_rdata;

	// Decodes one register offset, used by both the read and the write paths.
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction

	// Enables for each power state; the waking state powers everything back up.
	function automatic psw_gate_t gates_for(input psw_state_t s);
		psw_gate_t g;
		g = PSW_GATE_RESET;
		case (s)
			PSW_D1: g = '{mac_clk_en: 1'b0, host_if_clk_en: 1'b0, int_clk_en: 1'b1,
				rx_pm_en: 1'b1, phy_energy_powerdown: 1'b0};
			PSW_D2: g = '{mac_clk_en: 1'b0, host_if_clk_en: 1'b0, int_clk_en: 1'b0,
				rx_pm_en: 1'b0, phy_energy_powerdown: 1'b1};
			default: g = PSW_GATE_RESET;
		endcase
		gates_for = g;
	endfunction

	// The carrier comes straight from the PHY pin, so it is synchronised first.
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			carrier_meta <= 1'b0;
			carrier_sync <= 1'b0;
		end
		else
		begin
			carrier_meta <= carrier_detect;
			carrier_sync <= carrier_meta;
		end
	end

	// The slave never inserts wait states and always answers OKAY.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign ap_valid = hsel && htrans[1] && hready && (hsize == PSW_HSIZE_WORD);

	// Address phase capture for the following data phase.
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_addr <= 8'h00;
		end
		else if (hready)
		begin
			dp_valid <= ap_valid;
			dp_write <= ap_valid && hwrite;
			dp_addr <= haddr[7:0];
		end
	end

	// Writes need a prior read; while not ready only the wake write gets through.
	assign write_ok = dp_valid && dp_write && read_seen
		&& (ready || hit(dp_addr, PSW_OFS_WAKE));
	assign wake_write = write_ok && hit(dp_addr, PSW_OFS_WAKE)
		&& ((state == PSW_D1) || (state == PSW_D2));
	assign ctrl_write = write_ok && ready && hit(dp_addr, PSW_OFS_CTRL);
	assign sts_write = write_ok && ready && hit(dp_addr, PSW_OFS_INTERRUPT_STATUS_REG);
	assign en_write = write_ok && ready && hit(dp_addr, PSW_OFS_INT_EN);

	// A read arms writes; a return from sleep disarms them, and a read wins a tie.
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			read_seen <= 1'b0;
		else if (ap_valid && !hwrite)
			read_seen <= 1'b1;
		else if (wake_write)
			read_seen <= 1'b0;
	end

	// Power state sequencing; a reserved select value leaves the state alone.
	always_comb
	begin
		next_state = state;
		case (state)
			PSW_D0:
			begin
				if (ctrl_write && (hwdata[PSW_POS_MODE +: 2] == PSW_MODE_D1))
					next_state = PSW_D1;
				else if (ctrl_write && (hwdata[PSW_POS_MODE +: 2] == PSW_MODE_D2))
					next_state = PSW_D2;
			end
			PSW_D1, PSW_D2:
			begin
				if (wake_write)
					next_state = PSW_WAKING;
			end
			PSW_WAKING:
			begin
				if (ready_cnt == RW'(READY_CYCLES - 1))
					next_state = PSW_D0;
			end
			default: next_state = PSW_D0;
		endcase
	end

	// State, ready and the gate enables all follow the next state together.
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= PSW_D0;
			ready <= 1'b1;
			clk_gates <= PSW_GATE_RESET;
		end
		else
		begin
			state <= next_state;
			ready <= (next_state == PSW_D0);
			clk_gates <= gates_for(next_state);
		end
	end

	// Resume timer; counts only while waking so ready returns on a fixed bound.
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			ready_cnt <= '0;
		else if (state == PSW_WAKING)
			ready_cnt <= ready_cnt + RW'(1);
		else
			ready_cnt <= '0;
	end

	// Detection is armed by the sleep state itself, with no enable write.
	assign wake_frame_detect_armed = (state == PSW_D1);
	assign det_frame = (state == PSW_D1) && wake_frame_hit;
	// A level test on the carrier catches one already present at entry.
	assign det_energy = (state == PSW_D2) && carrier_sync;

	// Control fields; detection beats a software clear of the source field.
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			ctrl <= PSW_CTRL_RESET;
		else
		begin
			if (wake_write)
				ctrl.power_state_select <= PSW_MODE_D0;
			else if (ctrl_write && (hwdata[PSW_POS_MODE +: 2] != 2'h3))
				ctrl.power_state_select <= hwdata[PSW_POS_MODE +: 2];
			if (ctrl_write)
			begin
				ctrl.wake_frame_detect_enable <= hwdata[PSW_POS_WAKE_FRAME_DETECT_ENABLE];
				ctrl.energy_detect_enable <= hwdata[PSW_POS_ENERGY_DETECT_ENABLE];
				ctrl.wake_output_enable <= hwdata[PSW_POS_PME_EN];
				ctrl.wake_output_pulse_select <= hwdata[PSW_POS_PULSE];
			end
			if (det_frame)
				ctrl.wake_source_status <= PSW_WAKE_SOURCE_STATUS_FRAME;
			else if (det_energy)
				ctrl.wake_source_status <= PSW_WAKE_SOURCE_STATUS_ENERGY;
			else if (ctrl_write)
				ctrl.wake_source_status <= ctrl.wake_source_status
					& ~hwdata[PSW_POS_WAKE_SOURCE_STATUS +: 2];
		end
	end

	// Internal wake cause: a recorded source whose detect enable is still on.
	assign pme_line = (ctrl.wake_source_status[1] && ctrl.wake_frame_detect_enable)
		|| (ctrl.wake_source_status[0] && ctrl.energy_detect_enable);

	// Wake flag; the cause holds it, so a write of one only clears it afterwards.
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			pme_int <= 1'b0;
		else if (pme_line)
			pme_int <= 1'b1;
		else if (sts_write && hwdata[PSW_POS_PME_INT])
			pme_int <= 1'b0;
	end

	// Interrupt enable and the general scratch word.
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pme_int_en <= 1'b0;
			scratch <= 32'h00000000;
		end
		else
		begin
			if (en_write)
				pme_int_en <= hwdata[PSW_POS_PME_INT];
			if (write_ok && ready && hit(dp_addr, PSW_OFS_SCRATCH))
				scratch <= hwdata;
		end
	end

	// The host interrupt ignores the external output and its enable.
	assign host_irq = pme_int && pme_int_en;

	// External wake output in pulsed or static form.
	psw_wake_pulse #(
		.PULSE_CYCLES(PULSE_CYCLES)
	) u_wake_pulse (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.request(pme_line && ctrl.wake_output_enable),
		.pulse_mode(ctrl.wake_output_pulse_select),
		.wake_out(wake_event_out)
	);

	// Read mux; when not ready everything but the control register reads zero.
	always_comb
	begin
		next_rdata = 32'h00000000;
		if (hit(haddr[7:0], PSW_OFS_CTRL))
		begin
			next_rdata[PSW_POS_MODE +: 2] = ctrl.power_state_select;
			next_rdata[PSW_POS_READY] = ready;
			next_rdata[PSW_POS_WAKE_FRAME_DETECT_ENABLE] = ctrl.wake_frame_detect_enable;
			next_rdata[PSW_POS_ENERGY_DETECT_ENABLE] = ctrl.energy_detect_enable;
			next_rdata[PSW_POS_PME_EN] = ctrl.wake_output_enable;
			next_rdata[PSW_POS_PULSE] = ctrl.wake_output_pulse_select;
			next_rdata[PSW_POS_WAKE_SOURCE_STATUS +: 2] = ctrl.wake_source_status;
		end
		else if (ready && hit(haddr[7:0], PSW_OFS_INTERRUPT_STATUS_REG))
			next_rdata[PSW_POS_PME_INT] = pme_int;
		else if (ready && hit(haddr[7:0], PSW_OFS_INT_EN))
			next_rdata[PSW_POS_PME_INT] = pme_int_en;
		else if (ready && hit(haddr[7:0], PSW_OFS_WAKE))
			next_rdata = PSW_WAKE_PATTERN;
		else if (ready && hit(haddr[7:0], PSW_OFS_SCRATCH))
			next_rdata = scratch;
	end

	// Read data is sampled at the address phase, so it stands for the data phase.
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			hrdata <= 32'h00000000;
		else if (ap_valid && !hwrite)
			hrdata <= next_rdata;
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_wake_write;
		wake_write;
	endsequence

	sequence s_waking;
		(state == PSW_WAKING) && !ready && (ctrl.power_state_select == PSW_MODE_D0);
	endsequence

	sleep_not_ready_a: assert property ((state == PSW_D1 || state == PSW_D2) |-> !ready)
		else $error("ready set while asleep");

	sleep_read_zero_a: assert property (
		(ap_valid && !hwrite && !ready && !hit(haddr[7:0], PSW_OFS_CTRL)) |=> (hrdata == '0))
		else $error("non-control read returned data while not ready");

	write_gate_a: assert property (
		(dp_valid && dp_write && !read_seen) |=> $stable(scratch) && $stable(ctrl))
		else $error("write took effect before any read");

	wake_return_a: assert property (s_wake_write |=> s_waking)
		else $error("wake write did not start the return to D0");

	enter_d1_a: assert property (
		(state == PSW_D0 && ctrl_write && hwdata[PSW_POS_MODE +: 2] == PSW_MODE_D1)
		|=> (state == PSW_D1) && !ready && !clk_gates.mac_clk_en && clk_gates.rx_pm_en)
		else $error("D1 entry did not gate the MAC and clear ready");

	d2_gates_a: assert property (
		(state == PSW_D2) |-> !clk_gates.int_clk_en && clk_gates.phy_energy_powerdown)
		else $error("D2 left the internal clock running");

	frame_source_a: assert property (
		(state == PSW_D1 && wake_frame_hit) |=> (ctrl.wake_source_status == PSW_WAKE_SOURCE_STATUS_FRAME))
		else $error("frame detection did not record its source");

	energy_source_a: assert property (
		(state == PSW_D2 && carrier_sync) |=> (ctrl.wake_source_status == PSW_WAKE_SOURCE_STATUS_ENERGY))
		else $error("carrier in D2 did not record its source");

	flag_hold_a: assert property (pme_line |=> pme_int)
		else $error("wake flag cleared while its cause persists");

	ready_bound_a: assert property (
		(state == PSW_WAKING) |-> (ready_cnt < RW'(READY_CYCLES)))
		else $error("resume timer ran past its bound");

endmodule // psw_power_ctrl

// [shared/psw_pkg.sv]
package psw_pkg;

	// Byte offsets of the word registers on the bus.
	localparam logic [7:0] PSW_OFS_CTRL = 8'h00;
	localparam logic [7:0] PSW_OFS_INTERRUPT_STATUS_REG = 8'h04;
	localparam logic [7:0] PSW_OFS_INT_EN = 8'h08;
	localparam logic [7:0] PSW_OFS_WAKE = 8'h0C;
	localparam logic [7:0] PSW_OFS_SCRATCH = 8'h10;

	// Field positions inside the control register.
	localparam int PSW_POS_MODE = 0;
	localparam int PSW_POS_READY = 2;
	localparam int PSW_POS_WAKE_FRAME_DETECT_ENABLE = 3;
	localparam int PSW_POS_ENERGY_DETECT_ENABLE = 4;
	localparam int PSW_POS_PME_EN = 5;
	localparam int PSW_POS_PULSE = 6;
	localparam int PSW_POS_WAKE_SOURCE_STATUS = 8;
	// Field position of the wake flag in the status and enable registers.
	localparam int PSW_POS_PME_INT = 0;

	// Power state select encodings.
	localparam logic [1:0] PSW_MODE_D0 = 2'h0;
	localparam logic [1:0] PSW_MODE_D1 = 2'h1;
	localparam logic [1:0] PSW_MODE_D2 = 2'h2;

	// Wake source status encodings.
	localparam logic [1:0] PSW_WAKE_SOURCE_STATUS_NONE = 2'h0;
	localparam logic [1:0] PSW_WAKE_SOURCE_STATUS_ENERGY = 2'h1;
	localparam logic [1:0] PSW_WAKE_SOURCE_STATUS_FRAME = 2'h2;

	// Only whole-word transfers are decoded.
	localparam logic [2:0] PSW_HSIZE_WORD = 3'h2;

	// Fixed test pattern returned by the wake register; the value is arbitrary.
	localparam logic [31:0] PSW_WAKE_PATTERN = 32'h5A5AC3C3;

	// Timing, from the figures in milliseconds and the clock rate.
	localparam int PSW_CLK_KHZ = 100000;
	localparam int PSW_WAKE_PULSE_MS = 50;
	localparam int PSW_READY_MAX_MS = 2;
	localparam int PSW_WAKE_PULSE_CYCLES = PSW_WAKE_PULSE_MS * PSW_CLK_KHZ;
	localparam int PSW_READY_CYCLES = PSW_READY_MAX_MS * PSW_CLK_KHZ;

	// Power states of the sequencer.
	typedef enum logic [1:0] {PSW_D0, PSW_D1, PSW_D2, PSW_WAKING} psw_state_t;

	// Software-visible control fields.
	typedef struct packed {
		logic [1:0] wake_source_status;
		logic wake_output_pulse_select;
		logic wake_output_enable;
		logic energy_detect_enable;
		logic wake_frame_detect_enable;
		logic [1:0] power_state_select;
	} psw_ctrl_t;

	localparam psw_ctrl_t PSW_CTRL_RESET = '0;

	// Clock and power enables handed to the gated blocks.
	typedef struct packed {
		logic mac_clk_en;
		logic host_if_clk_en;
		logic int_clk_en;
		logic rx_pm_en;
		logic phy_energy_powerdown;
	} psw_gate_t;

	localparam psw_gate_t PSW_GATE_RESET = 5'h1E;

endpackage

// [core/psw_wake_pulse.sv]
`timescale 1ns/1ns
module psw_wake_pulse
	import psw_pkg::*;
#(
	parameter int PULSE_CYCLES = PSW_WAKE_PULSE_CYCLES
)
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic request,
	input wire logic pulse_mode,
	output logic wake_out
);

	localparam int CW = $clog2(PULSE_CYCLES + 1);

	logic request_d;
	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic next_out;

	// The pulse is timed from the rising edge of the request only.
	always_comb
	begin
		next_cnt = cnt;
		if (!request)
			next_cnt = '0;
		else if (!request_d && pulse_mode)
			next_cnt = CW'(PULSE_CYCLES);
		else if (cnt != '0)
			next_cnt = cnt - CW'(1);
		// Dropping the request ends either form at once.
		next_out = request && (pulse_mode ? (next_cnt != '0) : 1'b1);
	end

	// Edge memory of the request.
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			request_d <= 1'b0;
		else
			request_d <= request;
	end

	// Pulse counter and the registered output.
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cnt <= '0;
			wake_out <= 1'b0;
		end
		else
		begin
			cnt <= next_cnt;
			wake_out <= next_out;
		end
	end

	static_follow_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(!pulse_mode && request) |=> wake_out)
		else $error("static wake output did not follow its request");

	drop_clears_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!request |=> !wake_out)
		else $error("wake output stayed on after request dropped");

	pulse_bounded_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(pulse_mode && wake_out) |-> (cnt != '0))
		else $error("pulsed wake output outlived its timer");

endmodule // psw_wake_pulse

// [sim/psw_far_model.sv]
`timescale 1ns/1ns
// Stands in for the wake-frame filter and the line energy detector at the far side.
module psw_far_model
	import psw_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic frame_seen,
	input wire logic line_energy,
	input wire logic rx_on,
	output logic wake_frame_hit,
	output logic carrier_detect
);
	// The filter reports a frame only while its receive block is powered.
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			wake_frame_hit <= 1'b0;
		else
			wake_frame_hit <= frame_seen & rx_on;
	end

	// Energy is sensed even in energy-detect power-down, so carrier follows the line.
	assign carrier_detect = line_energy;
endmodule // psw_far_model

// [sim/testbench.sv]
`timescale 1ns/1ns
module testbench
	import psw_pkg::*;
;
	localparam int PULSE = 20;
	localparam int RDY = 8;
	localparam logic [4:0] D0G = 5'h1E;
	localparam logic [4:0] D1G = 5'h06;
	localparam logic [4:0] D2G = 5'h01;
	logic sys_clk, reset_n, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	wire logic hready;
	logic wake_frame_hit, carrier_detect, wake_frame_detect_armed, ready;
	logic host_irq, wake_event_out, frame_seen, line_energy;
	// Stands for the energy-detect power-down bit that the host sets in the PHY.
	logic phy_pd_req;
	psw_gate_t clk_gates;
	int num_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	int n;

	// Single slave, so its ready output is the bus ready.
	assign hready = hreadyout;

	psw_power_ctrl #(.PULSE_CYCLES(PULSE), .READY_CYCLES(RDY)) i_dut (
		.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.wake_frame_hit(wake_frame_hit), .carrier_detect(carrier_detect),
		.clk_gates(clk_gates), .wake_frame_detect_armed(wake_frame_detect_armed),
		.ready(ready), .host_irq(host_irq), .wake_event_out(wake_event_out));

	psw_far_model i_far (
		.sys_clk(sys_clk), .reset_n(reset_n), .frame_seen(frame_seen),
		.line_energy(line_energy), .rx_on(clk_gates.rx_pm_en),
		.wake_frame_hit(wake_frame_hit), .carrier_detect(carrier_detect));

	// Free-running 100 MHz clock.
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// A hung wait would otherwise never end the run.
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			final_report();
		end
	end

	task automatic final_report();
		$display("Checks %0d, errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One single word transfer; the master waits for hready in each phase.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string name);
		bus(1'b0, a, 32'h0);
		chk(name, rd, exp);
		chk("hresp", {31'h0, hresp}, 32'h0);
	endtask

	// Ready, gates, armed, host interrupt and wake output in one word.
	task automatic pins(input logic [8:0] exp);
		chk("pins", {23'h0, ready, clk_gates, wake_frame_detect_armed, host_irq,
			wake_event_out}, {23'h0, exp});
	endtask

	// Wake write, then ready must stay low at first and return within its bound.
	task automatic wake_up();
		wr(PSW_OFS_WAKE, 32'h0);
		n = 0;
		@(negedge sys_clk);
		while (ready !== 1'b1 && n < 50)
		begin
			n++;
			@(negedge sys_clk);
		end
		chk("ready_gap", {31'h0, n >= 1 && n <= RDY + 2}, 32'h1);
	endtask

	// A one-cycle frame hit from the filter, then time for the flags to settle.
	task automatic frame();
		@(posedge sys_clk);
		frame_seen <= 1'b1;
		@(posedge sys_clk);
		frame_seen <= 1'b0;
		repeat (6) @(negedge sys_clk);
	endtask

	initial
	begin
		reset_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = PSW_HSIZE_WORD;
		hwdata = 32'h0;
		frame_seen = 1'b0;
		line_energy = 1'b0;
		phy_pd_req = 1'b0;
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(negedge sys_clk);
		pins({1'b1, D0G, 1'b0, 1'b0, 1'b0});
		// Writes before the first read must be dropped.
		wr(PSW_OFS_SCRATCH, 32'h1234ABCD);
		rchk(PSW_OFS_SCRATCH, 32'h0, "early_write");
		wr(PSW_OFS_SCRATCH, 32'h1234ABCD);
		rchk(PSW_OFS_SCRATCH, 32'h1234ABCD, "scratch");
		rchk(8'hFC, 32'h0, "unmapped");
		wr(PSW_OFS_WAKE, 32'h0);
		rchk(PSW_OFS_WAKE, PSW_WAKE_PATTERN, "pattern");
		wr(PSW_OFS_CTRL, 32'h3);
		rchk(PSW_OFS_CTRL, 32'h4, "reserved_mode");
		wr(PSW_OFS_INT_EN, 32'h1);
		// Sleep with frame detection but the wake output disabled.
		wr(PSW_OFS_CTRL, 32'h9);
		@(negedge sys_clk);
		pins({1'b0, D1G, 1'b1, 1'b0, 1'b0});
		rchk(PSW_OFS_CTRL, 32'h9, "d1_ctrl");
		rchk(PSW_OFS_SCRATCH, 32'h0, "d1_hidden");
		wr(PSW_OFS_SCRATCH, 32'h0);
		frame();
		pins({1'b0, D1G, 1'b1, 1'b1, 1'b0});
		rchk(PSW_OFS_CTRL, 32'h209, "d1_source");
		wake_up();
		pins({1'b1, D0G, 1'b0, 1'b1, 1'b0});
		wr(PSW_OFS_SCRATCH, 32'h0);
		rchk(PSW_OFS_SCRATCH, 32'h1234ABCD, "wake_gate");
		rchk(PSW_OFS_CTRL, 32'h20C, "d0_restored");
		wr(PSW_OFS_CTRL, 32'h308);
		wr(PSW_OFS_INTERRUPT_STATUS_REG, 32'h1);
		rchk(PSW_OFS_CTRL, 32'hC, "source_clear");
		rchk(PSW_OFS_INTERRUPT_STATUS_REG, 32'h0, "flag_clear");
		// Sleep again with a static wake output.
		wr(PSW_OFS_CTRL, 32'h29);
		frame();
		pins({1'b0, D1G, 1'b1, 1'b1, 1'b1});
		wake_up();
		rchk(PSW_OFS_CTRL, 32'h22C, "d1b_ctrl");
		wr(PSW_OFS_INTERRUPT_STATUS_REG, 32'h1);
		rchk(PSW_OFS_INTERRUPT_STATUS_REG, 32'h1, "flag_hold");
		wr(PSW_OFS_CTRL, 32'h20);
		repeat (2) @(negedge sys_clk);
		pins({1'b1, D0G, 1'b0, 1'b1, 1'b0});
		wr(PSW_OFS_INTERRUPT_STATUS_REG, 32'h1);
		wr(PSW_OFS_CTRL, 32'h300);
		@(negedge sys_clk);
		pins({1'b1, D0G, 1'b0, 1'b0, 1'b0});
		// Energy sleep entered with carrier already on the line, pulsed output.
		@(posedge sys_clk);
		line_energy <= 1'b1;
		// The PHY goes into energy-detect power-down before the select write.
		phy_pd_req <= 1'b1;
		wr(PSW_OFS_CTRL, 32'h72);
		@(negedge sys_clk);
		pins({1'b0, D2G, 1'b0, 1'b0, 1'b0});
		chk("phy_pd", {31'h0, clk_gates.phy_energy_powerdown}, {31'h0, phy_pd_req});
		n = 0;
		while (wake_event_out !== 1'b1 && n < 20)
		begin
			n++;
			@(negedge sys_clk);
		end
		chk("pulse_start", {31'h0, n < 20}, 32'h1);
		n = 0;
		while (wake_event_out === 1'b1 && n < 100)
		begin
			n++;
			@(negedge sys_clk);
		end
		chk("pulse_len", n, PULSE);
		pins({1'b0, D2G, 1'b0, 1'b1, 1'b0});
		rchk(PSW_OFS_CTRL, 32'h172, "d2_source");
		wake_up();
		// The PHY power-down bit is released only once ready is back.
		chk("pd_after_ready", {31'h0, ready}, 32'h1);
		phy_pd_req <= 1'b0;
		@(posedge sys_clk);
		line_energy <= 1'b0;
		rchk(PSW_OFS_CTRL, 32'h174, "d2_restored");
		// A reset in the middle of a sleep must restore D0 and disarm writes again.
		wr(PSW_OFS_CTRL, 32'h9);
		@(posedge sys_clk);
		reset_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(negedge sys_clk);
		pins({1'b1, D0G, 1'b0, 1'b0, 1'b0});
		wr(PSW_OFS_SCRATCH, 32'h00000005);
		rchk(PSW_OFS_CTRL, 32'h4, "reset_ctrl");
		rchk(PSW_OFS_SCRATCH, 32'h0, "reset_gate");
		final_report();
	end
endmodule // testbench
